// *** core/acc_top.sv ***
// Analog comparator control with AXI4-Lite register access
`timescale 1ns/1ps
`include "acc_regs.svh"

module acc_top #(
  parameter int ADDR_W = 12,
  parameter int SYNC_STAGES = 2
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic cmp_raw,
  input wire logic irq_vector_ack,
  output logic pos_bandgap_sel,
  output logic neg_mux_sel,
  output logic [2:0] neg_channel_sel,
  output logic comparator_power_off,
  output logic capture_trigger,
  output logic comparator_irq_req,
  output logic irq
);

  // ----------------------------------------------------------------
  // Elaboration check and decode
  // ----------------------------------------------------------------
  generate
    if (ADDR_W < 10) begin : g_bad_addr
      $error("acc_top needs at least ten address bits");
    end
  endgenerate

  // Map a byte address onto a register
  function automatic acc_pkg::acc_reg_sel_t decode(
    input logic [ADDR_W-1:0] addr
  );
    logic [7:0] idx;
    idx = addr[9:2];
    if (addr[ADDR_W-1:10] != '0) begin
      decode = acc_pkg::ACC_SEL_NONE;
    end else begin
      case (idx)
        `ACC_IDX_CTRL_STATUS: decode = acc_pkg::ACC_SEL_CS;
        `ACC_IDX_CONV_CTRL_B: decode = acc_pkg::ACC_SEL_CB;
        `ACC_IDX_IRQ_STATUS: decode = acc_pkg::ACC_SEL_IST;
        `ACC_IDX_IRQ_MASK: decode = acc_pkg::ACC_SEL_IMK;
        `ACC_IDX_SYS_CTRL: decode = acc_pkg::ACC_SEL_SYS;
        default: decode = acc_pkg::ACC_SEL_NONE;
      endcase
    end
  endfunction : decode

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic aw_held_ff, nxt_aw_held, w_held_ff, nxt_w_held;
  logic [ADDR_W-1:0] awaddr_ff, nxt_awaddr;
  logic [7:0] wbyte_ff, nxt_wbyte;
  logic wlane_ff, nxt_wlane;
  logic awready_ff, nxt_awready, wready_ff, nxt_wready;
  logic bvalid_ff, nxt_bvalid, arready_ff, nxt_arready;
  logic rvalid_ff, nxt_rvalid;
  logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
  logic [31:0] rdata_ff, nxt_rdata;
  logic wr_fire;
  acc_pkg::acc_reg_sel_t wr_sel, rd_sel;
  logic [7:0] cs_word, cb_word, sys_word;

  logic disable_ff, nxt_disable, bandgap_ff, nxt_bandgap;
  logic flag_ff, nxt_flag, irq_en_ff, nxt_irq_en;
  logic capture_ff, nxt_capture;
  logic [1:0] mode_ff, nxt_mode;
  logic mux_en_ff, nxt_mux_en;
  logic [2:0] trig_ff, nxt_trig;
  logic gie_ff, nxt_gie, conv_en_ff, nxt_conv_en, prr_ff, nxt_prr;
  logic [2:0] chsel_ff, nxt_chsel;
  logic ist_ff, nxt_ist, imk_ff, nxt_imk;
  logic prev_ff, cmp_sync, rise, fall, event_hit;
  logic pos_bg_ff, neg_mux_ff, pwr_off_ff, cap_ff, req_ff, irq_ff;
  logic [2:0] neg_ch_ff;

  // ----------------------------------------------------------------
  // Synchroniser
  // ----------------------------------------------------------------
  acc_sync #(
    .STAGES(SYNC_STAGES)
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .din(cmp_raw),
    .dout(cmp_sync)
  );

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  assign wr_fire = aw_held_ff & w_held_ff & ~bvalid_ff;
  assign wr_sel = decode(awaddr_ff);
  assign rd_sel = decode(araddr);

  // Readable words
  assign cs_word = {disable_ff, bandgap_ff, cmp_sync, flag_ff,
                    irq_en_ff, capture_ff, mode_ff};
  assign cb_word = {1'b0, mux_en_ff, 3'h0, trig_ff};
  assign sys_word = {2'h0, prr_ff, chsel_ff, conv_en_ff, gie_ff};

  // Channel handshakes and answers
  always_comb begin
    nxt_aw_held = aw_held_ff;
    nxt_w_held = w_held_ff;
    nxt_awaddr = awaddr_ff;
    nxt_wbyte = wbyte_ff;
    nxt_wlane = wlane_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    nxt_rvalid = rvalid_ff;
    nxt_rresp = rresp_ff;
    nxt_rdata = rdata_ff;
    if (awvalid && awready_ff) begin
      nxt_aw_held = 1'b1;
      nxt_awaddr = awaddr;
    end
    if (wvalid && wready_ff) begin
      nxt_w_held = 1'b1;
      nxt_wbyte = wdata[7:0];
      nxt_wlane = wstrb[0];
    end
    if (bvalid_ff && bready) begin
      nxt_bvalid = 1'b0;
    end
    if (wr_fire) begin
      nxt_aw_held = 1'b0;
      nxt_w_held = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp = (wr_sel == acc_pkg::ACC_SEL_NONE) ?
                  `ACC_RESP_SLVERR : `ACC_RESP_OKAY;
    end
    if (rvalid_ff && rready) begin
      nxt_rvalid = 1'b0;
    end
    if (arvalid && arready_ff) begin
      nxt_rvalid = 1'b1;
      nxt_rresp = `ACC_RESP_OKAY;
      case (rd_sel)
        acc_pkg::ACC_SEL_CS: nxt_rdata = {24'h0, cs_word};
        acc_pkg::ACC_SEL_CB: nxt_rdata = {24'h0, cb_word};
        acc_pkg::ACC_SEL_IST: nxt_rdata = {31'h0, ist_ff};
        acc_pkg::ACC_SEL_IMK: nxt_rdata = {31'h0, imk_ff};
        acc_pkg::ACC_SEL_SYS: nxt_rdata = {24'h0, sys_word};
        default: begin
          nxt_rdata = 32'h0;
          nxt_rresp = `ACC_RESP_SLVERR;
        end
      endcase
    end
    nxt_awready = ~nxt_aw_held & ~nxt_bvalid;
    nxt_wready = ~nxt_w_held & ~nxt_bvalid;
    nxt_arready = ~nxt_rvalid;
  end

  // Register the bus state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      awaddr_ff <= '0;
      wbyte_ff <= 8'h00;
      wlane_ff <= 1'b0;
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      arready_ff <= 1'b1;
      bvalid_ff <= 1'b0;
      bresp_ff <= 2'h0;
      rvalid_ff <= 1'b0;
      rresp_ff <= 2'h0;
      rdata_ff <= 32'h0;
    end else begin
      aw_held_ff <= nxt_aw_held;
      w_held_ff <= nxt_w_held;
      awaddr_ff <= nxt_awaddr;
      wbyte_ff <= nxt_wbyte;
      wlane_ff <= nxt_wlane;
      awready_ff <= nxt_awready;
      wready_ff <= nxt_wready;
      arready_ff <= nxt_arready;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      rvalid_ff <= nxt_rvalid;
      rresp_ff <= nxt_rresp;
      rdata_ff <= nxt_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Control registers, event detection and routing
  // ----------------------------------------------------------------
  assign rise = cmp_sync & ~prev_ff;
  assign fall = ~cmp_sync & prev_ff;

  // Next values of control state and event_hit
  always_comb begin
    nxt_disable = disable_ff;
    nxt_bandgap = bandgap_ff;
    nxt_irq_en = irq_en_ff;
    nxt_capture = capture_ff;
    nxt_mode = mode_ff;
    nxt_mux_en = mux_en_ff;
    nxt_trig = trig_ff;
    nxt_gie = gie_ff;
    nxt_conv_en = conv_en_ff;
    nxt_prr = prr_ff;
    nxt_chsel = chsel_ff;
    nxt_imk = imk_ff;
    nxt_flag = flag_ff;
    nxt_ist = ist_ff;
    // Event chosen by the mode field
    case (mode_ff)
      `ACC_MODE_TOGGLE: event_hit = rise | fall;
      `ACC_MODE_FALL: event_hit = fall;
      `ACC_MODE_RISE: event_hit = rise;
      default: event_hit = 1'b0;
    endcase
    if (irq_vector_ack) begin
      nxt_flag = 1'b0;
    end
    if (wr_fire && wlane_ff) begin
      case (wr_sel)
        acc_pkg::ACC_SEL_CS: begin
          nxt_disable = wbyte_ff[`ACC_CS_DISABLE];
          nxt_bandgap = wbyte_ff[`ACC_CS_BANDGAP];
          nxt_irq_en = wbyte_ff[`ACC_CS_IRQ_EN];
          nxt_capture = wbyte_ff[`ACC_CS_CAPTURE];
          nxt_mode = wbyte_ff[`ACC_CS_MODE_HIGH:`ACC_CS_MODE_LOW];
          if (wbyte_ff[`ACC_CS_IRQ_FLAG]) begin
            nxt_flag = 1'b0;
          end
        end
        acc_pkg::ACC_SEL_CB: begin
          nxt_mux_en = wbyte_ff[`ACC_CB_MUX_EN];
          nxt_trig = wbyte_ff[`ACC_CB_TRIG_HIGH:`ACC_CB_TRIG_LOW];
        end
        acc_pkg::ACC_SEL_IST: begin
          if (wbyte_ff[0]) begin
            nxt_ist = 1'b0;
          end
        end
        acc_pkg::ACC_SEL_IMK: nxt_imk = wbyte_ff[0];
        acc_pkg::ACC_SEL_SYS: begin
          nxt_gie = wbyte_ff[`ACC_SYS_GIE];
          nxt_conv_en = wbyte_ff[`ACC_SYS_CONV_EN];
          nxt_prr = wbyte_ff[`ACC_SYS_PRR];
          nxt_chsel = wbyte_ff[`ACC_SYS_CHSEL_HIGH:`ACC_SYS_CHSEL_LOW];
        end
        default: nxt_imk = imk_ff;
      endcase
    end
    // Hardware set wins over any clear
    if (event_hit) begin
      nxt_flag = 1'b1;
      nxt_ist = 1'b1;
    end
  end

  // Register control state and drive outputs from flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      disable_ff <= 1'b0;
      bandgap_ff <= 1'b0;
      irq_en_ff <= 1'b0;
      capture_ff <= 1'b0;
      mode_ff <= 2'h0;
      mux_en_ff <= 1'b0;
      trig_ff <= 3'h0;
      gie_ff <= 1'b0;
      conv_en_ff <= 1'b0;
      prr_ff <= 1'b0;
      chsel_ff <= 3'h0;
      imk_ff <= 1'b0;
      flag_ff <= 1'b0;
      ist_ff <= 1'b0;
      prev_ff <= 1'b0;
      pos_bg_ff <= 1'b0;
      neg_mux_ff <= 1'b0;
      neg_ch_ff <= 3'h0;
      pwr_off_ff <= 1'b0;
      cap_ff <= 1'b0;
      req_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      disable_ff <= nxt_disable;
      bandgap_ff <= nxt_bandgap;
      irq_en_ff <= nxt_irq_en;
      capture_ff <= nxt_capture;
      mode_ff <= nxt_mode;
      mux_en_ff <= nxt_mux_en;
      trig_ff <= nxt_trig;
      gie_ff <= nxt_gie;
      conv_en_ff <= nxt_conv_en;
      prr_ff <= nxt_prr;
      chsel_ff <= nxt_chsel;
      imk_ff <= nxt_imk;
      flag_ff <= nxt_flag;
      ist_ff <= nxt_ist;
      prev_ff <= cmp_sync;
      pos_bg_ff <= bandgap_ff;
      neg_mux_ff <= mux_en_ff & ~conv_en_ff & ~prr_ff;
      neg_ch_ff <= chsel_ff;
      pwr_off_ff <= disable_ff;
      cap_ff <= capture_ff & cmp_sync;
      req_ff <= irq_en_ff & gie_ff & flag_ff;
      irq_ff <= ist_ff & imk_ff;
    end
  end

  // ----------------------------------------------------------------
  // Output ports
  // ----------------------------------------------------------------
  assign awready = awready_ff;
  assign wready = wready_ff;
  assign bvalid = bvalid_ff;
  assign bresp = bresp_ff;
  assign arready = arready_ff;
  assign rvalid = rvalid_ff;
  assign rresp = rresp_ff;
  assign rdata = rdata_ff;
  assign pos_bandgap_sel = pos_bg_ff;
  assign neg_mux_sel = neg_mux_ff;
  assign neg_channel_sel = neg_ch_ff;
  assign comparator_power_off = pwr_off_ff;
  assign capture_trigger = cap_ff;
  assign comparator_irq_req = req_ff;
  assign irq = irq_ff;

endmodule : acc_top

// *** inc/acc_regs.svh ***
// Register indices, field positions, reset values and mode codes
`ifndef ACC_REGS_SVH
`define ACC_REGS_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define ACC_IDX_CTRL_STATUS 8'h50
`define ACC_IDX_CONV_CTRL_B 8'h7B
`define ACC_IDX_IRQ_STATUS 8'h80
`define ACC_IDX_IRQ_MASK 8'h81
`define ACC_IDX_SYS_CTRL 8'h82

// ----------------------------------------------------------------
// comparator_control_status fields
// ----------------------------------------------------------------
`define ACC_CS_DISABLE 7
`define ACC_CS_BANDGAP 6
`define ACC_CS_OUTPUT 5
`define ACC_CS_IRQ_FLAG 4
`define ACC_CS_IRQ_EN 3
`define ACC_CS_CAPTURE 2
`define ACC_CS_MODE_HIGH 1
`define ACC_CS_MODE_LOW 0

// ----------------------------------------------------------------
// converter_control_b fields
// ----------------------------------------------------------------
`define ACC_CB_MUX_EN 6
`define ACC_CB_TRIG_HIGH 2
`define ACC_CB_TRIG_LOW 0

// ----------------------------------------------------------------
// system_control fields
// ----------------------------------------------------------------
`define ACC_SYS_GIE 0
`define ACC_SYS_CONV_EN 1
`define ACC_SYS_CHSEL_LOW 2
`define ACC_SYS_CHSEL_HIGH 4
`define ACC_SYS_PRR 5

// ----------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------
`define ACC_RST_BYTE 8'h00
`define ACC_MODE_TOGGLE 2'h0
`define ACC_MODE_FALL 2'h2
`define ACC_MODE_RISE 2'h3
`define ACC_RESP_OKAY 2'h0
`define ACC_RESP_SLVERR 2'h2

`endif

// *** inc/acc_pkg.sv ***
// Types shared by the comparator control block
package acc_pkg;

  // Register selected by a bus address
  typedef enum logic [2:0] {
    ACC_SEL_NONE,
    ACC_SEL_CS,
    ACC_SEL_CB,
    ACC_SEL_IST,
    ACC_SEL_IMK,
    ACC_SEL_SYS
  } acc_reg_sel_t;

endpackage : acc_pkg

// *** core/acc_sync.sv ***
// Multi-stage synchroniser for the raw comparator result
`timescale 1ns/1ps

module acc_sync #(
  parameter int STAGES = 2
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic din,
  output logic dout
);

  logic [STAGES-1:0] stage_ff;
  logic [STAGES-1:0] nxt_stage;

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  generate
    if (STAGES < 2) begin : g_bad_stages
      $error("acc_sync needs at least two stages");
    end
  endgenerate

  // Shift chain, first stage feeds only the second
  always_comb begin
    nxt_stage = {stage_ff[STAGES-2:0], din};
  end

  // Register the chain
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stage_ff <= '0;
    end else begin
      stage_ff <= nxt_stage;
    end
  end

  assign dout = stage_ff[STAGES-1];

endmodule : acc_sync

// *** verification/acc_cmp_model.sv ***
// Behavioural comparator core with its input selection
`timescale 1ns/1ps
module acc_cmp_model (
  input wire logic pos_bandgap_sel, neg_mux_sel, comparator_power_off,
  input wire logic [2:0] neg_channel_sel,
  input wire logic [7:0] v_pos, v_neg, v_bg,
  input wire logic [63:0] v_ch,
  output logic cmp_raw
);
  logic [7:0] vp;
  logic [7:0] vn;
  // Pick both inputs, then compare; unpowered core gives low
  always_comb begin
    vp = pos_bandgap_sel ? v_bg : v_pos;
    vn = neg_mux_sel ? v_ch[{neg_channel_sel, 3'h0} +: 8] : v_neg;
    cmp_raw = !comparator_power_off && (vp > vn);
  end
endmodule : acc_cmp_model

// *** verification/acc_top_monitor.sv ***
// Port-level checks for the comparator control block
`timescale 1ns/1ps
module acc_top_monitor #(
  parameter int ADDR_W = 12,
  parameter int SYNC_STAGES = 2
) (
  input wire logic aclk, aresetn, awvalid, awready, wvalid, wready,
  input wire logic bvalid, bready, arvalid, arready, rvalid, rready,
  input wire logic [ADDR_W-1:0] awaddr, araddr,
  input wire logic [31:0] wdata, rdata,
  input wire logic [3:0] wstrb,
  input wire logic [1:0] bresp, rresp,
  input wire logic cmp_raw, irq_vector_ack, pos_bandgap_sel, neg_mux_sel,
  input wire logic [2:0] neg_channel_sel,
  input wire logic comparator_power_off, capture_trigger,
  input wire logic comparator_irq_req, irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Bus answers hold until taken
  a_bvalid_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write answer dropped early");
  a_rvalid_hold: assert property (rvalid && !rready |=>
    rvalid && $stable(rdata) && $stable(rresp))
    else $error("read answer dropped early");
  a_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  a_read_refuse: assert property (arvalid && arready && (araddr >> 10) != 0
    |=> rresp == 2'h2 && rdata == 32'h0)
    else $error("unmapped read not refused");
  a_write_block: assert property (bvalid |-> !awready && !wready)
    else $error("new write taken during answer");
  a_write_reopen: assert property (bvalid && bready |=> awready && wready)
    else $error("write channel not reopened");
  // Capture follows the synchronised result only
  a_cap_source: assert property (capture_trigger |->
    $past(cmp_raw, 2) || $past(cmp_raw, 3) || $past(cmp_raw, 4))
    else $error("capture without comparator high");
  // Output bit reflects a settled result
  a_out_sync: assert property (arvalid && arready && araddr == 12'h140 &&
    $past(aresetn, 4) && $stable(cmp_raw) && $past(cmp_raw) == $past(cmp_raw, 3)
    && $past(cmp_raw, 2) == $past(cmp_raw, 3) |=> rdata[5] == $past(cmp_raw, 3))
    else $error("output bit wrong");
  a_reset_clear: assert property ($rose(aresetn) |-> !comparator_power_off &&
    !neg_mux_sel && !pos_bandgap_sel && !irq && !comparator_irq_req)
    else $error("outputs not cleared by reset");
  c_irq: cover property ($rose(irq));
  c_cap: cover property ($rose(capture_trigger));
  c_refuse: cover property (bvalid && bready && bresp == 2'h2);
endmodule : acc_top_monitor
bind acc_top acc_top_monitor #(.ADDR_W(ADDR_W), .SYNC_STAGES(SYNC_STAGES))
  u_mon (.*);

// *** verification/analog_comparator_control_bench.sv ***
// Self-checking bench for the comparator control block
`timescale 1ns/1ps
module analog_comparator_control_bench;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, cmp_raw, irq_vector_ack;
  logic pos_bandgap_sel, neg_mux_sel, comparator_power_off;
  logic capture_trigger, comparator_irq_req, irq;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [2:0] neg_channel_sel;
  logic [7:0] v_pos, v_neg, v_bg;
  logic [63:0] v_ch;
  int bad_count, num_checks;

  acc_top u_dut (.*);
  acc_cmp_model u_cmp (.*);

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  task automatic cy(input int n);
    repeat (n) @(posedge aclk);
  endtask : cy

  // Write one byte register, judge the response code
  task automatic wr(input logic [11:0] a, input logic [7:0] d,
                    input logic [1:0] er);
    int n;
    bit aw_done;
    bit w_done;
    bit b_done;
    n = 0;
    aw_done = 1'b0;
    w_done = 1'b0;
    b_done = 1'b0;
    // Let an edge pass so no signal is assigned twice in one step
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!(aw_done && w_done && b_done) && n < 60) begin
      @(posedge aclk);
      if (!aw_done && awready) begin
        awvalid <= 1'h0;
        aw_done = 1'b1;
      end
      if (!w_done && wready) begin
        wvalid <= 1'h0;
        w_done = 1'b1;
      end
      if (!b_done && bvalid) begin
        bready <= 1'h0;
        b_done = 1'b1;
        chk("bresp", er, bresp);
      end
      n++;
    end
    if (n >= 60) chk("write_done", 1'h0, 1'h1);
  endtask : wr

  // Read one register, judge data and response code
  task automatic rchk(input logic [11:0] a, input logic [7:0] e,
                      input logic [1:0] er);
    int n;
    bit ar_done;
    bit r_done;
    n = 0;
    ar_done = 1'b0;
    r_done = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    while (!(ar_done && r_done) && n < 60) begin
      @(posedge aclk);
      if (!ar_done && arready) begin
        arvalid <= 1'h0;
        ar_done = 1'b1;
      end
      if (!r_done && rvalid) begin
        rready <= 1'h0;
        r_done = 1'b1;
        chk("rdata", {24'h0, e}, rdata);
        chk("rresp", er, rresp);
      end
      n++;
    end
    if (n >= 60) chk("read_done", 1'h0, 1'h1);
  endtask : rchk

  task automatic tally_and_finish;
    if (bad_count == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    rchk(12'h140, 8'h00, 2'h0);
    rchk(12'h1EC, 8'h00, 2'h0);
    rchk(12'h400, 8'h00, 2'h2);
    wr(12'h400, 8'hFF, 2'h2);
    wr(12'h1EC, 8'hFF, 2'h0);
    rchk(12'h1EC, 8'h47, 2'h0);
    wr(12'h1EC, 8'h00, 2'h0);
    cy(3);
    chk("neg_mux", 1'h0, neg_mux_sel);
  endtask : t_regs

  // Input routing with the reserved mode so no flag is raised
  task automatic t_route;
    wr(12'h140, 8'h11, 2'h0);
    v_pos <= 8'h96;
    wr(12'h208, 8'h14, 2'h0);
    wr(12'h1EC, 8'h40, 2'h0);
    cy(4);
    chk("neg_mux", 1'h1, neg_mux_sel);
    chk("channel", 3'h5, neg_channel_sel);
    rchk(12'h140, 8'h01, 2'h0);
    wr(12'h208, 8'h16, 2'h0);
    cy(4);
    chk("neg_mux", 1'h0, neg_mux_sel);
    rchk(12'h140, 8'h21, 2'h0);
    wr(12'h208, 8'h34, 2'h0);
    cy(4);
    chk("neg_mux", 1'h0, neg_mux_sel);
    wr(12'h208, 8'h14, 2'h0);
    wr(12'h140, 8'h41, 2'h0);
    cy(4);
    chk("bandgap", 1'h1, pos_bandgap_sel);
    rchk(12'h140, 8'h41, 2'h0);
    v_ch[47:40] <= 8'h50;
    cy(5);
    rchk(12'h140, 8'h61, 2'h0);
    wr(12'h140, 8'hC1, 2'h0);
    cy(5);
    chk("power_off", 1'h1, comparator_power_off);
    rchk(12'h140, 8'hC1, 2'h0);
    v_pos <= 8'h32;
    wr(12'h140, 8'h01, 2'h0);
    wr(12'h1EC, 8'h00, 2'h0);
    wr(12'h208, 8'h00, 2'h0);
    cy(6);
  endtask : t_route

  // Every mode against a rise, then a fall
  task automatic t_modes;
    for (int m = 0; m < 4; m++) begin
      wr(12'h140, 8'h10 | m[7:0], 2'h0);
      v_pos <= 8'h96;
      cy(6);
      rchk(12'h140, 8'h20 | m[7:0] | ((m == 0 || m == 3) ? 8'h10 : 8'h00),
           2'h0);
      wr(12'h140, 8'h10 | m[7:0], 2'h0);
      v_pos <= 8'h32;
      cy(6);
      rchk(12'h140, m[7:0] | ((m == 0 || m == 2) ? 8'h10 : 8'h00),
           2'h0);
    end
  endtask : t_modes

  task automatic t_irq;
    wr(12'h208, 8'h01, 2'h0);
    wr(12'h204, 8'h01, 2'h0);
    wr(12'h200, 8'h01, 2'h0);
    wr(12'h140, 8'h13, 2'h0);
    wr(12'h140, 8'h1B, 2'h0);
    v_pos <= 8'h96;
    cy(6);
    chk("irq_req", 1'h1, comparator_irq_req);
    chk("irq", 1'h1, irq);
    irq_vector_ack <= 1'h1;
    @(posedge aclk);
    irq_vector_ack <= 1'h0;
    cy(3);
    chk("irq_req", 1'h0, comparator_irq_req);
    chk("irq", 1'h1, irq);
    wr(12'h200, 8'h01, 2'h0);
    cy(2);
    chk("irq", 1'h0, irq);
    wr(12'h204, 8'h00, 2'h0);
    v_pos <= 8'h32;
    cy(4);
    v_pos <= 8'h96;
    cy(6);
    chk("irq", 1'h0, irq);
    chk("irq_req", 1'h1, comparator_irq_req);
    rchk(12'h200, 8'h01, 2'h0);
    wr(12'h208, 8'h00, 2'h0);
    cy(3);
    chk("irq_req", 1'h0, comparator_irq_req);
    wr(12'h140, 8'h13, 2'h0);
    wr(12'h200, 8'h01, 2'h0);
  endtask : t_irq

  task automatic t_cap;
    wr(12'h140, 8'h05, 2'h0);
    cy(4);
    chk("capture", 1'h1, capture_trigger);
    v_pos <= 8'h32;
    cy(6);
    chk("capture", 1'h0, capture_trigger);
    v_pos <= 8'h96;
    wr(12'h140, 8'h01, 2'h0);
    cy(6);
    chk("capture", 1'h0, capture_trigger);
  endtask : t_cap

  // ----------------------------------------------------------------
  // Clock, reset, sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    aclk = 1'h0;
    forever #20 aclk = ~aclk;
  end

  initial begin
    aresetn = 1'h0;
    {awvalid, wvalid, bready, arvalid, rready, irq_vector_ack} = 6'h0;
    awaddr = 12'h0;
    araddr = 12'h0;
    wdata = 32'h0;
    wstrb = 4'hF;
    v_pos = 8'h32;
    v_neg = 8'h64;
    v_bg = 8'h78;
    v_ch = 64'h0000_C800_0000_0000;
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    t_regs;
    t_route;
    t_modes;
    t_irq;
    t_cap;
    tally_and_finish;
  end

  initial begin
    #400000;
    bad_count++;
    tally_and_finish;
  end
endmodule : analog_comparator_control_bench
